// [dce_pkg.sv]
// Shared constants for the DRAM controller with error correction
// Notes on behaviour
// - Controller clock is synchronized to the 8 MHz processor clock.
// - Each access drives row and column strobes; write strobe only on writes.
// - Processor accesses and refresh are arbitrated; both get serviced.
// - Every DRAM row is refreshed within the required refresh interval.
// - Addresses 1 MB as two banks of 256K by 22 one-bit parts.
// - Single-bit errors are corrected, double-bit errors detected.
// - Writes store computed check bits with the data word together.
// - Reads are checked and corrected before data goes to the processor.
// - Word writes complete with no wait state unless a burst refresh owns the memory.
// - Every read inserts at least one wait state for DRAM access time.
// - Error-free reads release wait after the minimum wait state.
// - Reads with an error hold wait two further wait states.
// - Processor is told of wait states and of uncorrectable errors.
// - Six check bits per sixteen-bit word, modified Hamming code.
// - Eight rows refreshed per 125 us period, all 256 rows in 4 ms.
// - Each access sequence starts from the address latch strobe.
// - Uncorrectable read errors raise the non-maskable interrupt request.
package dce_pkg;

  localparam int CLK_MHZ       = 125;
  localparam int CPU_CLK_MHZ   = 8;
  localparam int DATA_W        = 16;
  localparam int CHECK_W       = 6;
  localparam int WORD_W        = DATA_W + CHECK_W;
  localparam int ADDR_W        = 20;
  localparam int DRAM_A_W      = 9;
  localparam int BANKS         = 2;
  localparam int BANK_BIT      = 19;
  localparam int ROW_LSB       = 10;
  localparam int COL_LSB       = 1;
  localparam int REF_ROW_W     = 8;

  // DRAM timing in ns and their cycle counts (least times round up)
  localparam int T_RCD_NS      = 20;
  localparam int T_ACCESS_NS   = 120;
  localparam int T_RAS_NS      = 120;
  localparam int T_PRE_NS      = 100;
  localparam int T_WAIT_NS     = 1000 / CPU_CLK_MHZ;
  localparam int RCD_CYC       = (T_RCD_NS * CLK_MHZ + 999) / 1000;
  localparam int ACCESS_CYC    = (T_ACCESS_NS * CLK_MHZ + 999) / 1000;
  localparam int RAS_CYC       = (T_RAS_NS * CLK_MHZ + 999) / 1000;
  localparam int PRE_CYC       = (T_PRE_NS * CLK_MHZ + 999) / 1000;
  localparam int WAIT_CYC      = (T_WAIT_NS * CLK_MHZ + 999) / 1000;
  localparam int ERR_WAITS     = 2;
  localparam int ERR_CYC       = ERR_WAITS * WAIT_CYC;
  localparam int CNT_W         = 8;

  // Refresh budget
  localparam int T_REF_PERIOD_US = 125;
  localparam int REF_PERIOD_CYC  = T_REF_PERIOD_US * CLK_MHZ;
  localparam int REF_PER_PERIOD  = 8;
  localparam int OWED_W          = 5;
  localparam int OWED_MAX        = 31;

  // Code positions of the data bits in the Hamming word
  localparam logic [4:0] DATA_POS [DATA_W] = '{
    5'h03, 5'h05, 5'h06, 5'h07, 5'h09, 5'h0A, 5'h0B, 5'h0C,
    5'h0D, 5'h0E, 5'h0F, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15};

  typedef enum logic [2:0] {
    DCE_IDLE, DCE_ROW, DCE_COL, DCE_ERRW, DCE_PRE, DCE_REF
  } dce_state_e;

endpackage

// [dce_ecc.sv]
// Single-error-correct, double-error-detect code for one 16-bit word
`timescale 1ns/1ps
module dce_ecc
  import dce_pkg::*;
(
  // Write path
  input  wire logic [DATA_W-1:0]  wr_data,
  output logic      [CHECK_W-1:0] wr_check,
  // Read path
  input  wire logic [DATA_W-1:0]  rd_data,
  input  wire logic [CHECK_W-1:0] rd_check,
  output logic      [DATA_W-1:0]  fixed_data,
  output logic                    err_any,
  output logic                    err_fatal
);

  // Five Hamming bits plus an overall parity bit giving even word parity
  function automatic logic [CHECK_W-1:0] calc_check(logic [DATA_W-1:0] d);
    logic [CHECK_W-1:0] c;
    c = '0;
    for (int b = 0; b < CHECK_W-1; b++) begin
      for (int i = 0; i < DATA_W; i++) begin
        if (DATA_POS[i][b]) begin
          c[b] = c[b] ^ d[i];
        end
      end
    end
    c[CHECK_W-1] = ^d ^ ^c[CHECK_W-2:0];
    return c;
  endfunction

  logic [CHECK_W-1:0] rd_calc;
  logic [4:0]         syndrome;
  logic               par_err;

  assign wr_check = calc_check(wr_data);
  assign rd_calc  = calc_check(rd_data);
  assign syndrome = rd_calc[CHECK_W-2:0] ^ rd_check[CHECK_W-2:0];
  assign par_err  = ^{rd_data, rd_check};

  // Odd parity means a single error; even parity with a syndrome is double
  assign err_any   = par_err | (syndrome != '0);
  assign err_fatal = ~par_err & (syndrome != '0);

  always_comb begin
    fixed_data = rd_data;
    for (int i = 0; i < DATA_W; i++) begin
      if (par_err && DATA_POS[i] == syndrome) begin
        fixed_data[i] = ~rd_data[i];
      end
    end
  end

endmodule

// [dce_ctrl.sv]
// DRAM controller top: access timing, refresh arbitration, wait and ECC
`timescale 1ns/1ps
module dce_ctrl
  import dce_pkg::*;
#(
  parameter int REF_PERIOD = REF_PERIOD_CYC
)(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Processor side pins
  input  wire logic                  cpu_ale,
  input  wire logic                  cpu_mem_sel,
  input  wire logic                  bus_is_read,
  input  wire logic                  bus_is_write,
  input  wire logic [ADDR_W-1:0]     cpu_addr,
  input  wire logic [DATA_W-1:0]     cpu_wr_data,
  output logic      [DATA_W-1:0]     cpu_rd_data,
  output logic                       cpu_rd_data_oe,
  output logic                       cpu_wait,
  output logic                       cpu_hold,
  output logic                       cpu_nmi_req,
  // DRAM side pins
  output logic      [DRAM_A_W-1:0]   dram_addr,
  output logic      [BANKS-1:0]      dram_ras_n,
  output logic                       dram_cas_n,
  output logic                       dram_we_n,
  input  wire logic [WORD_W-1:0]     dram_dq_in,
  output logic      [WORD_W-1:0]     dram_dq_out,
  output logic                       dram_dq_oe
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic              ale_s1_reg, ale_s2_reg, ale_s3_reg;
  logic              sel_s1_reg, sel_s2_reg;
  logic              rd_s1_reg, rd_s2_reg;
  logic              wr_s1_reg, wr_s2_reg;
  logic [ADDR_W-1:0] addr_s1_reg, addr_s2_reg;
  logic [DATA_W-1:0] wdat_s1_reg, wdat_s2_reg;
  logic              ale_rise;

  // The controller clock is derived in step with the processor clock,
  // but pins still pass two stages so no edge lands mid-sample.
  always_ff @(posedge clk) begin
    if (rst) begin
      ale_s1_reg <= 1'b0;
      ale_s2_reg <= 1'b0;
      ale_s3_reg <= 1'b0;
      sel_s1_reg <= 1'b0;
      sel_s2_reg <= 1'b0;
      rd_s1_reg  <= 1'b0;
      rd_s2_reg  <= 1'b0;
      wr_s1_reg  <= 1'b0;
      wr_s2_reg  <= 1'b0;
    end else begin
      ale_s1_reg <= cpu_ale;
      ale_s2_reg <= ale_s1_reg;
      ale_s3_reg <= ale_s2_reg;
      sel_s1_reg <= cpu_mem_sel;
      sel_s2_reg <= sel_s1_reg;
      rd_s1_reg  <= bus_is_read;
      rd_s2_reg  <= rd_s1_reg;
      wr_s1_reg  <= bus_is_write;
      wr_s2_reg  <= wr_s1_reg;
    end
  end

  always_ff @(posedge clk) begin
    addr_s1_reg <= cpu_addr;
    addr_s2_reg <= addr_s1_reg;
    wdat_s1_reg <= cpu_wr_data;
    wdat_s2_reg <= wdat_s1_reg;
  end

  assign ale_rise = ale_s2_reg & ~ale_s3_reg;

  ////////////////////////////////////////////////////////////////////////
  // Request capture
  logic              req_reg;
  logic              req_read_reg;
  logic [ADDR_W-1:0] req_addr_reg;
  logic              acc_start;
  dce_state_e        state_reg;
  logic [CNT_W-1:0]  cnt_reg;

  // Bus controller marks the cycle as read or write; non-memory cycles
  // leave the DRAM free for hidden refresh.
  always_ff @(posedge clk) begin
    if (rst) begin
      req_reg      <= 1'b0;
      req_read_reg <= 1'b0;
      req_addr_reg <= '0;
    end else if (ale_rise && sel_s2_reg && (rd_s2_reg || wr_s2_reg)) begin
      req_reg      <= 1'b1;
      req_read_reg <= rd_s2_reg;
      req_addr_reg <= addr_s2_reg;
    end else if (acc_start) begin
      req_reg      <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Refresh budget
  logic [$clog2(REF_PERIOD)-1:0] ref_tmr_reg;
  logic                          ref_tick;
  logic [OWED_W-1:0]             owed_reg;
  logic [OWED_W:0]               owed_sum;
  logic                          ref_done;
  logic                          burst_reg;
  logic [REF_ROW_W-1:0]          ref_row_reg;

  assign ref_tick = (ref_tmr_reg == '0);

  always_ff @(posedge clk) begin
    if (rst) begin
      ref_tmr_reg <= '0;
    end else if (ref_tick) begin
      ref_tmr_reg <= ($clog2(REF_PERIOD))'(REF_PERIOD - 1);
    end else begin
      ref_tmr_reg <= ref_tmr_reg - 1'b1;
    end
  end

  // A refresh finishing on the tick cycle is still counted.
  always_comb begin
    owed_sum = {1'b0, owed_reg};
    if (ref_tick) begin
      owed_sum = owed_sum + (OWED_W+1)'(REF_PER_PERIOD);
    end
    if (ref_done) begin
      owed_sum = owed_sum - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      owed_reg <= '0;
    end else if (owed_sum > (OWED_W+1)'(OWED_MAX)) begin
      owed_reg <= OWED_W'(OWED_MAX);
    end else begin
      owed_reg <= owed_sum[OWED_W-1:0];
    end
  end

  // Rows left over at the period end force a burst that holds the CPU
  always_ff @(posedge clk) begin
    if (rst) begin
      burst_reg <= 1'b0;
    end else if (ref_tick && owed_reg != '0) begin
      burst_reg <= 1'b1;
    end else if (owed_reg == '0) begin
      burst_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ref_row_reg <= '0;
    end else if (ref_done) begin
      ref_row_reg <= ref_row_reg + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Timing generator
  logic [WORD_W-1:0] wr_word;
  logic [CHECK_W-1:0] wr_check;
  logic [DATA_W-1:0] fixed_data;
  logic              err_any;
  logic              err_fatal;
  logic              cnt_zero;
  logic              bank;

  assign cnt_zero  = (cnt_reg == '0);
  assign bank      = req_addr_reg[BANK_BIT];
  // Priority: owed burst, then the CPU, then hidden refresh when idle
  assign acc_start = (state_reg == DCE_IDLE) && req_reg && !burst_reg;
  assign ref_done  = (state_reg == DCE_REF) && cnt_zero;
  assign wr_word   = {wr_check, wdat_s2_reg};

  dce_ecc u_ecc (
    .wr_data    (wdat_s2_reg),
    .wr_check   (wr_check),
    .rd_data    (dram_dq_in[DATA_W-1:0]),
    .rd_check   (dram_dq_in[WORD_W-1:DATA_W]),
    .fixed_data (fixed_data),
    .err_any    (err_any),
    .err_fatal  (err_fatal)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= DCE_IDLE;
      cnt_reg   <= '0;
    end else begin
      unique case (state_reg)
        DCE_IDLE: begin
          if (acc_start) begin
            state_reg <= DCE_ROW;
            cnt_reg   <= CNT_W'(RCD_CYC - 1);
          end else if (owed_reg != '0) begin
            state_reg <= DCE_REF;
            cnt_reg   <= CNT_W'(RAS_CYC - 1);
          end
        end
        DCE_ROW: begin
          if (cnt_zero) begin
            state_reg <= DCE_COL;
            cnt_reg   <= CNT_W'(ACCESS_CYC - 1);
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        DCE_COL: begin
          if (!cnt_zero) begin
            cnt_reg <= cnt_reg - 1'b1;
          end else if (req_read_reg && err_any) begin
            state_reg <= DCE_ERRW;
            cnt_reg   <= CNT_W'(ERR_CYC - 1);
          end else begin
            state_reg <= DCE_PRE;
            cnt_reg   <= CNT_W'(PRE_CYC - 1);
          end
        end
        DCE_ERRW: begin
          if (cnt_zero) begin
            state_reg <= DCE_PRE;
            cnt_reg   <= CNT_W'(PRE_CYC - 1);
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        DCE_PRE: begin
          if (cnt_zero) begin
            state_reg <= DCE_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        DCE_REF: begin
          if (cnt_zero) begin
            state_reg <= DCE_PRE;
            cnt_reg   <= CNT_W'(PRE_CYC - 1);
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        default: begin
          state_reg <= DCE_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // DRAM pins
  always_ff @(posedge clk) begin
    if (rst) begin
      dram_ras_n  <= '1;
      dram_cas_n  <= 1'b1;
      dram_we_n   <= 1'b1;
      dram_addr   <= '0;
      dram_dq_out <= '0;
      dram_dq_oe  <= 1'b0;
    end else begin
      dram_ras_n  <= '1;
      dram_cas_n  <= 1'b1;
      dram_we_n   <= 1'b1;
      dram_dq_oe  <= 1'b0;
      unique case (state_reg)
        DCE_ROW: begin
          dram_ras_n[bank] <= 1'b0;
          dram_addr <= req_addr_reg[ROW_LSB +: DRAM_A_W];
        end
        DCE_COL: begin
          dram_ras_n[bank] <= 1'b0;
          dram_cas_n       <= 1'b0;
          dram_addr <= req_addr_reg[COL_LSB +: DRAM_A_W];
          if (!req_read_reg) begin
            dram_we_n   <= 1'b0;
            dram_dq_out <= wr_word;
            dram_dq_oe  <= 1'b1;
          end
        end
        DCE_REF: begin
          // RAS-only refresh of the same row in both banks
          dram_ras_n <= '0;
          dram_addr  <= DRAM_A_W'(ref_row_reg);
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Processor answer
  logic wait_reg;

  // Wait rises with the latch strobe of a read so the CPU sees it in time;
  // writes never wait unless a burst refresh owns the memory.
  always_ff @(posedge clk) begin
    if (rst) begin
      wait_reg <= 1'b0;
    end else if (ale_rise && sel_s2_reg && rd_s2_reg) begin
      wait_reg <= 1'b1;
    end else if (state_reg == DCE_COL && cnt_zero && !err_any) begin
      wait_reg <= 1'b0;
    end else if (state_reg == DCE_ERRW && cnt_zero) begin
      wait_reg <= 1'b0;
    end
  end

  assign cpu_wait = wait_reg | (burst_reg & req_reg);
  assign cpu_hold = burst_reg;

  // Data word is corrected before it reaches the bus
  always_ff @(posedge clk) begin
    if (rst) begin
      cpu_rd_data    <= '0;
      cpu_rd_data_oe <= 1'b0;
    end else if (state_reg == DCE_COL && cnt_zero && req_read_reg) begin
      cpu_rd_data    <= fixed_data;
      cpu_rd_data_oe <= 1'b1;
    end else if (ale_rise) begin
      cpu_rd_data_oe <= 1'b0;
    end
  end

  // Interrupt request stands until the next address latch strobe of any bus cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      cpu_nmi_req <= 1'b0;
    end else if (state_reg == DCE_COL && cnt_zero && req_read_reg &&
                 err_fatal) begin
      cpu_nmi_req <= 1'b1;
    end else if (ale_rise) begin
      cpu_nmi_req <= 1'b0;
    end
  end

endmodule

// [dce_ctrl_asserts.sv]
// Concurrent checks on the DRAM controller top ports
`timescale 1ns/1ps
module dce_ctrl_asserts
  import dce_pkg::*;
(
  // Clock and reset
  input wire logic             clk,
  input wire logic             rst,
  // Processor side
  input wire logic             cpu_ale,
  input wire logic             cpu_mem_sel,
  input wire logic             bus_is_read,
  input wire logic             cpu_wait,
  input wire logic             cpu_hold,
  input wire logic             cpu_nmi_req,
  input wire logic             cpu_rd_data_oe,
  // DRAM side
  input wire logic [BANKS-1:0] dram_ras_n,
  input wire logic             dram_cas_n,
  input wire logic             dram_we_n,
  input wire logic             dram_dq_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence read_req;
    $rose(cpu_ale) && cpu_mem_sel && bus_is_read;
  endsequence
  sequence col_open;
    $fell(dram_cas_n) ##0 (dram_ras_n != 2'h3);
  endsequence

  wait_early_a: assert property (read_req |-> ##[1:8] cpu_wait)
    else $error("wait not raised early in read");
  wait_min_a: assert property ($rose(cpu_wait) && !cpu_hold |->
    cpu_wait[*8]) else $error("wait state too short");
  cas_in_row_a: assert property ($fell(dram_cas_n) |->
    dram_ras_n != 2'h3) else $error("column strobe without row");
  cas_width_a: assert property (col_open |-> !dram_cas_n[*8])
    else $error("column strobe too short for access");
  write_col_a: assert property (!dram_we_n |->
    !dram_cas_n && dram_dq_oe) else $error("write strobe outside column");
  write_nowait_a: assert property (!dram_we_n |->
    !cpu_wait || cpu_hold) else $error("wait during word write");
  refresh_ras_a: assert property (dram_ras_n == 2'h0 |->
    dram_cas_n) else $error("column strobe during refresh");
  nmi_hold_a: assert property (cpu_nmi_req && !cpu_ale |=>
    cpu_nmi_req) else $error("error request dropped early");
  rd_oe_a: assert property (cpu_rd_data_oe |-> !dram_dq_oe)
    else $error("read data driven during DRAM write");
endmodule

bind dce_ctrl dce_ctrl_asserts u_chk (
  .clk(clk), .rst(rst), .cpu_ale(cpu_ale), .cpu_mem_sel(cpu_mem_sel),
  .bus_is_read(bus_is_read), .cpu_wait(cpu_wait), .cpu_hold(cpu_hold),
  .cpu_nmi_req(cpu_nmi_req), .cpu_rd_data_oe(cpu_rd_data_oe),
  .dram_ras_n(dram_ras_n), .dram_cas_n(dram_cas_n),
  .dram_we_n(dram_we_n), .dram_dq_oe(dram_dq_oe));

// [dce_dram_model.sv]
// Behavioural DRAM array answering the controller's strobes
`timescale 1ns/1ps
module dce_dram_model
  import dce_pkg::*;
(
  // Strobes and address
  input  wire logic [BANKS-1:0]    ras_n,
  input  wire logic                cas_n,
  input  wire logic                we_n,
  input  wire logic [DRAM_A_W-1:0] addr,
  // Data, with bits flipped on read to fake soft errors
  input  wire logic [WORD_W-1:0]   d_in,
  input  wire logic [WORD_W-1:0]   flip,
  output logic      [WORD_W-1:0]   d_out
);
  logic [WORD_W-1:0]   mem [int];
  logic [DRAM_A_W-1:0] row;
  logic                bank;
  logic [WORD_W-1:0]   rd_word;
  int                  k;

  // Row and bank taken at the falling row strobe
  always @(negedge ras_n[0] or negedge ras_n[1]) begin
    row = addr;
    bank = ras_n[0];
  end
  always @(cas_n or we_n or d_in or addr) begin
    if (!cas_n && !we_n) begin
      mem[{bank, row, addr}] = d_in;
    end
  end
  always @* begin
    k = {bank, row, addr};
    rd_word = mem.exists(k) ? mem[k] : '0;
  end
  // Released bus shows the inverse, so stale data never reads as good
  assign d_out = (!cas_n && we_n) ? rd_word ^ flip : ~(rd_word ^ flip);
endmodule

// [dce_ctrl_tb.sv]
// Self-checking testbench for the DRAM controller with error correction
`timescale 1ns/1ps
module dce_ctrl_tb;
  import dce_pkg::*;
  localparam int REF_P = 2000;
  logic                clk, rst, cpu_ale, cpu_mem_sel;
  logic                bus_is_read, bus_is_write;
  logic [ADDR_W-1:0]   cpu_addr;
  logic [DATA_W-1:0]   cpu_wr_data, cpu_rd_data;
  logic                cpu_rd_data_oe, cpu_wait, cpu_hold, cpu_nmi_req;
  logic [DRAM_A_W-1:0] dram_addr;
  logic [BANKS-1:0]    dram_ras_n;
  logic                dram_cas_n, dram_we_n, dram_dq_oe;
  logic [WORD_W-1:0]   dram_dq_in, dram_dq_out, flip, wr_word;
  logic [7:0]          w, w_clean;
  int                  num_errors = 0;
  int                  n_tests = 0;

  dce_ctrl #(.REF_PERIOD(REF_P)) uut (.clk(clk), .rst(rst),
    .cpu_ale(cpu_ale), .cpu_mem_sel(cpu_mem_sel),
    .bus_is_read(bus_is_read), .bus_is_write(bus_is_write),
    .cpu_addr(cpu_addr), .cpu_wr_data(cpu_wr_data),
    .cpu_rd_data(cpu_rd_data), .cpu_rd_data_oe(cpu_rd_data_oe),
    .cpu_wait(cpu_wait), .cpu_hold(cpu_hold), .cpu_nmi_req(cpu_nmi_req),
    .dram_addr(dram_addr), .dram_ras_n(dram_ras_n),
    .dram_cas_n(dram_cas_n), .dram_we_n(dram_we_n),
    .dram_dq_in(dram_dq_in), .dram_dq_out(dram_dq_out),
    .dram_dq_oe(dram_dq_oe));
  dce_dram_model u_mem (.ras_n(dram_ras_n), .cas_n(dram_cas_n),
    .we_n(dram_we_n), .addr(dram_addr), .d_in(dram_dq_out),
    .flip(flip), .d_out(dram_dq_in));

  ////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (10000) @(posedge clk);
    num_errors++;
    summarize;
  end

  ////////////////////////////////////////////////////////////////////
  task check(input logic [21:0] seen, input logic [21:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task summarize;
    if (num_errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  function automatic logic [5:0] chk(input logic [15:0] d);
    logic [5:0] c;
    c = '0;
    for (int i = 0; i < DATA_W; i++) begin
      for (int b = 0; b < 5; b++) begin
        if (DATA_POS[i][b]) c[b] ^= d[i];
      end
    end
    c[5] = ^{c[4:0], d};
    return c;
  endfunction
  // One processor memory cycle; counts the wait cycles it saw
  task cyc(input logic rd, input logic [19:0] a, input logic [15:0] d);
    w = 8'h00;
    while (cpu_hold) @(negedge clk);
    cpu_addr <= a;
    cpu_wr_data <= d;
    bus_is_read <= rd;
    bus_is_write <= !rd;
    cpu_mem_sel <= 1'b1;
    cpu_ale <= 1'b1;
    repeat (100) begin
      @(posedge clk);
      #1;
      if (cpu_wait) w++;
      if (!dram_we_n) wr_word = dram_dq_out;
    end
    @(negedge clk);
    {cpu_ale, cpu_mem_sel, bus_is_read, bus_is_write} <= 4'h0;
    repeat (5) @(negedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////
  task t_refresh;
    int cnt;
    logic [1:0] prv;
    cnt = 0;
    prv = 2'h3;
    repeat (REF_P) begin
      @(posedge clk);
      #1;
      if (dram_ras_n == 2'h0 && prv != 2'h0) cnt++;
      prv = dram_ras_n;
    end
    check(22'(cnt >= REF_PER_PERIOD), 22'h1);
  endtask
  task t_write_read(input logic [19:0] a, input logic [15:0] d);
    flip = '0;
    cyc(1'b0, a, d);
    check(22'(w), 22'h0);
    check(22'(cpu_hold), 22'h0);
    check(wr_word, {chk(d), d});
    cyc(1'b1, a, 16'h0000);
    w_clean = w;
    check(22'(cpu_rd_data), 22'(d));
    check(22'(cpu_rd_data_oe), 22'h1);
    check(22'(w >= WAIT_CYC), 22'h1);
    check(22'(cpu_nmi_req), 22'h0);
  endtask
  task t_single_err(input logic [19:0] a, input logic [15:0] d);
    for (int i = 0; i < 2; i++) begin
      flip = i ? 22'h040000 : 22'h000020;
      cyc(1'b1, a, 16'h0000);
      check(22'(cpu_rd_data), 22'(d));
      check(22'(w - w_clean), 22'(ERR_CYC));
      check(22'(cpu_nmi_req), 22'h0);
    end
  endtask
  task t_double_err(input logic [19:0] a);
    flip = 22'h000003;
    cyc(1'b1, a, 16'h0000);
    check(22'(cpu_nmi_req), 22'h1);
    flip = '0;
  endtask

  ////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    {cpu_ale, cpu_mem_sel, bus_is_read, bus_is_write} = 4'h0;
    cpu_addr = '0;
    cpu_wr_data = '0;
    flip = '0;
    wr_word = '0;
    repeat (12) @(negedge clk);
    rst <= 1'b0;
    t_refresh;
    repeat (300) @(negedge clk);
    t_write_read(20'h00002, 16'hA5C3);
    t_single_err(20'h00002, 16'hA5C3);
    t_double_err(20'h00002);
    t_write_read(20'hFFFFE, 16'h5A3C);
    t_single_err(20'hFFFFE, 16'h5A3C);
    summarize;
  end
endmodule
